// *** testbench/testbench.sv ***
`timescale 1ns/1ps
// ****************************************
// Self-checking bench for the execution stage
// ****************************************
module testbench;
    import nsx_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_valid = 1'b0;
    nsx_instr_t i_instr = '0;
    logic [7:0] o_w;
    logic o_zero;
    logic [7:0] o_port_a_dir;
    logic [7:0] o_port_b_dir;
    logic [7:0] o_port_c_dir;
    nsx_mem_wr_t o_mem_wr;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    // A 40 MHz clock, 25 ns period.
    always #12.5 i_ref_clk = ~i_ref_clk;
    nsx_exec i_dut (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_valid(i_valid),
        .i_instr(i_instr),
        .o_w(o_w),
        .o_zero(o_zero),
        .o_port_a_dir(o_port_a_dir),
        .o_port_b_dir(o_port_b_dir),
        .o_port_c_dir(o_port_c_dir),
        .o_mem_wr(o_mem_wr)
    );
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Cuts a hang short well after the tests should have ended.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            give_verdict();
        end
    end
    // Compares one value seen against the value expected.
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // Waits a falling edge, then presents one instruction for one cycle.
    // Results are settled on return and the write pulse still stands.
    task automatic run(input nsx_op_t op, input logic d, input logic [6:0] a,
                       input logic [7:0] k, input logic [7:0] m);
        @(negedge i_ref_clk);
        i_instr = '{op, d, a, k, m};
        i_valid = 1'b1;
        @(negedge i_ref_clk);
        i_valid = 1'b0;
    endtask
    // Two literal xors: nonzero then zero result, W only.
    task automatic t_xor_lit();
        run(NSX_OP_XOR_LITERAL, 1'b1, 7'h00, 8'h5A, 8'h00);
        chk("w", 8'h5A, o_w);
        chk("zero", 8'h00, {7'h00, o_zero});
        chk("we", 8'h00, {7'h00, o_mem_wr.we});
        run(NSX_OP_XOR_LITERAL, 1'b0, 7'h00, 8'h5A, 8'h00);
        chk("w", 8'h00, o_w);
        chk("zero", 8'h01, {7'h00, o_zero});
        $display("test xor literal done");
    endtask
    // Swap into W and into the byte; zero flag left at one.
    task automatic t_swap();
        run(NSX_OP_NIBBLE_SWAP, 1'b0, 7'h12, 8'h00, 8'h3C);
        chk("w", 8'hC3, o_w);
        chk("zero", 8'h01, {7'h00, o_zero});
        run(NSX_OP_NIBBLE_SWAP, 1'b1, 7'h12, 8'h00, 8'hA5);
        chk("we", 8'h01, {7'h00, o_mem_wr.we});
        chk("data", 8'h5A, o_mem_wr.data);
        chk("addr", 8'h12, {1'h0, o_mem_wr.addr});
        chk("w", 8'hC3, o_w);
        $display("test swap done");
    endtask
    // Direction loads for operands 7 down to 4; the last is refused and changes nothing.
    task automatic t_dir();
        for (int i = 7; i > 3; i--) begin
            run(NSX_OP_XOR_LITERAL, 1'b0, 7'h00, o_w ^ 8'(i * 16), 8'h00);
            run(NSX_OP_DIRECTION_LOAD, 1'b0, 7'(i), 8'h00, 8'h00);
        end
        chk("dir a", 8'h50, o_port_a_dir);
        chk("dir b", 8'h60, o_port_b_dir);
        chk("dir c", 8'h70, o_port_c_dir);
        chk("w", 8'h40, o_w);
        $display("test direction load done");
    endtask
    // Memory xor into the byte with zero result, then into W.
    task automatic t_xor_mem();
        run(NSX_OP_XOR_MEMORY, 1'b1, 7'h7F, 8'h00, 8'h40);
        chk("we", 8'h01, {7'h00, o_mem_wr.we});
        chk("data", 8'h00, o_mem_wr.data);
        chk("addr", 8'h7F, {1'h0, o_mem_wr.addr});
        chk("w", 8'h40, o_w);
        chk("zero", 8'h01, {7'h00, o_zero});
        run(NSX_OP_XOR_MEMORY, 1'b0, 7'h7F, 8'h00, 8'h0F);
        chk("w", 8'h4F, o_w);
        chk("zero", 8'h00, {7'h00, o_zero});
        chk("we", 8'h00, {7'h00, o_mem_wr.we});
        $display("test xor memory done");
    endtask
    // Back to back: the load in the next cycle already sees the new W.
    // Then an empty operation, which must leave everything alone.
    task automatic t_back();
        @(negedge i_ref_clk);
        i_instr = '{NSX_OP_XOR_LITERAL, 1'b0, 7'h00, 8'hFF, 8'h00};
        i_valid = 1'b1;
        @(negedge i_ref_clk);
        i_instr = '{NSX_OP_DIRECTION_LOAD, 1'b0, 7'h05, 8'h00, 8'h00};
        @(negedge i_ref_clk);
        i_valid = 1'b0;
        chk("w", 8'hB0, o_w);
        chk("dir a", 8'hB0, o_port_a_dir);
        chk("dir b", 8'h60, o_port_b_dir);
        run(NSX_OP_NONE, 1'b1, 7'h33, 8'hFF, 8'hFF);
        chk("we", 8'h00, {7'h00, o_mem_wr.we});
        chk("w", 8'hB0, o_w);
        $display("test back to back done");
    endtask
    // Values held while reset is low, seen just after its release.
    task automatic t_reset();
        chk("dir a", 8'hFF, o_port_a_dir);
        chk("dir b", 8'hFF, o_port_b_dir);
        chk("dir c", 8'hFF, o_port_c_dir);
        chk("w", 8'h00, o_w);
        chk("zero", 8'h00, {7'h00, o_zero});
        chk("we", 8'h00, {7'h00, o_mem_wr.we});
        $display("test reset done");
    endtask
    // Main sequence: reset for 4 cycles, then every test in turn.
    initial begin
        repeat (4) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        t_reset();
        t_xor_lit();
        t_swap();
        t_dir();
        t_xor_mem();
        t_back();
        give_verdict();
    end
endmodule

// *** verilog/nsx_alu.sv ***
`timescale 1ns/1ps
`include "nsx_defines.svh"

// Combinational result path for the swap and exclusive-OR operations.
module nsx_alu (
    // Operation and operands.
    input wire nsx_pkg::nsx_op_t i_op,
    input wire logic [7:0] i_w,
    input wire logic [7:0] i_literal,
    input wire logic [7:0] i_mem_data,
    // Result.
    output logic [7:0] o_result,
    output logic o_zero
);
    import nsx_pkg::*;

    // Selects the result byte and flags a zero result.
    always_comb begin
        case (i_op)
            NSX_OP_NIBBLE_SWAP: o_result = {i_mem_data[3:0], i_mem_data[7:4]};
            NSX_OP_XOR_LITERAL: o_result = i_w ^ i_literal;
            NSX_OP_XOR_MEMORY: o_result = i_w ^ i_mem_data;
            default: o_result = i_w;
        endcase
        o_zero = (o_result == 8'h00);
    end

endmodule

// *** verilog/nsx_defines.svh ***
`ifndef NSX_DEFINES_SVH
`define NSX_DEFINES_SVH

// Operand value that selects each port direction register.
`define NSX_DIR_SEL_A 3'h5
`define NSX_DIR_SEL_B 3'h6
`define NSX_DIR_SEL_C 3'h7

// Reset values: working register clear, all port pins inputs.
`define NSX_W_RESET 8'h00
`define NSX_DIR_RESET 8'hFF
`define NSX_ZERO_RESET 1'h0

// Destination-select encodings.
`define NSX_DEST_W 1'h0
`define NSX_DEST_F 1'h1

`endif

// *** verilog/nsx_exec.sv ***
`timescale 1ns/1ps
`include "nsx_defines.svh"
// Contract
// - Nibble swap puts low nibble high and high nibble low; no flags change.
// - Nibble swap result goes to W when dest is 0, to the byte when 1.
// - Direction load: W to port A, B or C direction for operand 5, 6, 7.
// - Xor literal: W xor 8-bit immediate into W, only zero flag updated.
// - Xor memory: W xor byte, into W when dest is 0, byte when 1.

// ****************************************
// Execution stage for four operations
// ****************************************
module nsx_exec (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Decoded instruction, valid for one cycle.
    input wire logic i_valid,
    input wire nsx_pkg::nsx_instr_t i_instr,
    // Architectural state outputs.
    output logic [7:0] o_w,
    output logic o_zero,
    output logic [7:0] o_port_a_dir,
    output logic [7:0] o_port_b_dir,
    output logic [7:0] o_port_c_dir,
    // Data memory write-back.
    output nsx_pkg::nsx_mem_wr_t o_mem_wr
);
    import nsx_pkg::*;

    // Result and steering for the instruction executing in this cycle.
    logic [7:0] result;
    logic result_zero;
    logic to_w;
    logic to_f;
    logic is_xor;

    // ****************************************
    // Datapath
    // ****************************************
    // Result byte and its zero test for the current instruction.
    nsx_alu u_alu (
        .i_op(i_instr.op),
        .i_w(o_w),
        .i_literal(i_instr.literal),
        .i_mem_data(i_instr.mem_data),
        .o_result(result),
        .o_zero(result_zero)
    );

    // True for the operations whose result follows the destination-select bit.
    // Literal xor is not among them: it always writes W.
    function automatic logic follows_dest(input nsx_op_t op);
        return op == NSX_OP_NIBBLE_SWAP || op == NSX_OP_XOR_MEMORY;
    endfunction

    // Destination steering for the operations that write a result.
    // The literal xor ignores the select bit and always lands in W.
    assign is_xor = i_valid && (i_instr.op == NSX_OP_XOR_LITERAL
                    || i_instr.op == NSX_OP_XOR_MEMORY);
    assign to_w = i_valid && (i_instr.op == NSX_OP_XOR_LITERAL
                  || (follows_dest(i_instr.op)
                  && i_instr.dest == `NSX_DEST_W));
    assign to_f = i_valid && follows_dest(i_instr.op)
                  && i_instr.dest == `NSX_DEST_F;

    // ****************************************
    // State
    // ****************************************
    // Working register. Every update lands at the edge that takes the
    // instruction, so the next instruction already sees the new W.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_w <= `NSX_W_RESET;
        end else if (to_w) begin
            o_w <= result;
        end
    end

    // Zero flag, touched only by the exclusive-OR operations.
    // Swap and direction load must leave it, so it is gated by is_xor.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_zero <= `NSX_ZERO_RESET;
        end else if (is_xor) begin
            o_zero <= result_zero;
        end
    end

    // Port direction registers. Only the low three operand bits are decoded, so an
    // operand of 13 also loads port A; the decoder upstream keeps operands in range.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_port_a_dir <= `NSX_DIR_RESET;
            o_port_b_dir <= `NSX_DIR_RESET;
            o_port_c_dir <= `NSX_DIR_RESET;
        end else if (i_valid && i_instr.op == NSX_OP_DIRECTION_LOAD) begin
            case (i_instr.addr[2:0])
                `NSX_DIR_SEL_A: o_port_a_dir <= o_w;
                `NSX_DIR_SEL_B: o_port_b_dir <= o_w;
                `NSX_DIR_SEL_C: o_port_c_dir <= o_w;
                default: ;
            endcase
        end
    end

    // Memory write-back pulse, one cycle per write.
    // Address and data follow the instruction every cycle; only we qualifies them.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mem_wr <= '0;
        end else begin
            o_mem_wr.we <= to_f;
            o_mem_wr.addr <= i_instr.addr;
            o_mem_wr.data <= result;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Each check looks one edge after the instruction was taken.
    // W as the instruction taken at the previous edge saw it.
    logic [7:0] w_prev;
    always_ff @(posedge i_ref_clk) begin
        w_prev <= o_w;
    end

    // Swap: routing of the result, flags left alone.
    swap_to_w_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_NIBBLE_SWAP && !i_instr.dest
        |=> o_w == {$past(i_instr.mem_data[3:0]), $past(i_instr.mem_data[7:4])})
        else $error("Swap result into W wrong.");
    swap_keeps_z_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_NIBBLE_SWAP |=> $stable(o_zero))
        else $error("Swap changed zero flag.");
    swap_to_mem_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_NIBBLE_SWAP && i_instr.dest
        |=> o_mem_wr.we && $stable(o_w)
            && o_mem_wr.data == {$past(i_instr.mem_data[3:0]), $past(i_instr.mem_data[7:4])})
        else $error("Swap write-back wrong.");
    swap_no_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_NIBBLE_SWAP && !i_instr.dest
        |=> !o_mem_wr.we)
        else $error("Swap into W wrote memory.");
    mem_addr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && (i_instr.op == NSX_OP_NIBBLE_SWAP || i_instr.op == NSX_OP_XOR_MEMORY)
        && i_instr.dest |=> o_mem_wr.addr == $past(i_instr.addr))
        else $error("Write-back address wrong.");

    // Direction loads: at most one register takes W, nothing else moves.
    dir_load_b_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_DIRECTION_LOAD && i_instr.addr[2:0] == 3'h6
        |=> o_port_b_dir == w_prev && $stable(o_port_a_dir) && $stable(o_port_c_dir))
        else $error("Direction load to port B wrong.");
    dir_load_a_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_DIRECTION_LOAD && i_instr.addr[2:0] == 3'h5
        |=> o_port_a_dir == w_prev && $stable(o_port_b_dir) && $stable(o_port_c_dir))
        else $error("Direction load to port A wrong.");
    dir_load_c_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_DIRECTION_LOAD && i_instr.addr[2:0] == 3'h7
        |=> o_port_c_dir == w_prev && $stable(o_port_a_dir) && $stable(o_port_b_dir))
        else $error("Direction load to port C wrong.");
    dir_refused_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_DIRECTION_LOAD && i_instr.addr[2:0] < 3'h5
        |=> $stable(o_port_a_dir) && $stable(o_port_b_dir) && $stable(o_port_c_dir))
        else $error("Refused direction load changed a register.");
    dir_keeps_z_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_DIRECTION_LOAD
        |=> $stable(o_zero) && $stable(o_w) && !o_mem_wr.we)
        else $error("Direction load touched W, flag or memory.");

    // Exclusive-OR: result, destination and zero flag.
    xor_literal_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_XOR_LITERAL
        |=> o_w == (w_prev ^ $past(i_instr.literal)) && !o_mem_wr.we)
        else $error("Xor literal result wrong.");
    xor_mem_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_XOR_MEMORY && i_instr.dest
        |=> o_mem_wr.we && o_mem_wr.data == (w_prev ^ $past(i_instr.mem_data)))
        else $error("Xor memory write-back wrong.");
    xor_mem_w_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_XOR_MEMORY && !i_instr.dest
        |=> o_w == (w_prev ^ $past(i_instr.mem_data)) && !o_mem_wr.we)
        else $error("Xor memory into W wrong.");
    xor_keeps_w_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_XOR_MEMORY && i_instr.dest
        |=> $stable(o_w))
        else $error("Xor memory into the byte changed W.");
    xor_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_XOR_MEMORY
        |=> o_zero == ((w_prev ^ $past(i_instr.mem_data)) == 8'h00))
        else $error("Zero flag mismatch.");
    xor_lit_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_XOR_LITERAL
        |=> o_zero == ((w_prev ^ $past(i_instr.literal)) == 8'h00))
        else $error("Zero flag after literal xor mismatch.");

    // Idle cycles and the empty operation leave all state alone.
    no_op_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_valid |=> !o_mem_wr.we && $stable(o_w))
        else $error("State changed with no instruction.");
    no_op_dirs_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_valid |=> $stable(o_zero) && $stable(o_port_a_dir)
            && $stable(o_port_b_dir) && $stable(o_port_c_dir))
        else $error("Flag or direction changed with no instruction.");
    op_none_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_valid && i_instr.op == NSX_OP_NONE
        |=> !o_mem_wr.we && $stable(o_w) && $stable(o_zero))
        else $error("Empty operation changed state.");

    // Main scenarios that the bench is expected to reach, back-to-back
    // issue among them.
    swap_cov_c: cover property (@(posedge i_ref_clk)
        i_valid && i_instr.op == NSX_OP_NIBBLE_SWAP && i_instr.dest);
    dir_cov_c: cover property (@(posedge i_ref_clk)
        i_valid && i_instr.op == NSX_OP_DIRECTION_LOAD);
    zero_cov_c: cover property (@(posedge i_ref_clk) is_xor && result_zero);
    xor_w_cov_c: cover property (@(posedge i_ref_clk)
        i_valid && i_instr.op == NSX_OP_XOR_MEMORY && !i_instr.dest);
    back_cov_c: cover property (@(posedge i_ref_clk) i_valid ##1 i_valid);

endmodule

// *** verilog/nsx_pkg.sv ***
package nsx_pkg;

    // Operation selected by the instruction decoder.
    typedef enum logic [2:0] {
        NSX_OP_NONE,
        NSX_OP_NIBBLE_SWAP,
        NSX_OP_DIRECTION_LOAD,
        NSX_OP_XOR_LITERAL,
        NSX_OP_XOR_MEMORY
    } nsx_op_t;

    // One decoded instruction presented to the datapath.
    typedef struct packed {
        nsx_op_t op;
        logic dest;
        logic [6:0] addr;
        logic [7:0] literal;
        logic [7:0] mem_data;
    } nsx_instr_t;

    // Write-back towards data memory.
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } nsx_mem_wr_t;

endpackage
